//--- include/e1sp_consts.svh
`ifndef E1SP_CONSTS_SVH
`define E1SP_CONSTS_SVH
// register offsets on the parallel microprocessor bus
`define E1SP_SLIP_IRQ_EN_ADDR 12'hB09
`define E1SP_LOOP_STATUS_ADDR 12'hB0A
`define E1SP_LOOP_IRQ_EN_ADDR 12'hB0B
`define E1SP_FRAMER_CFG_ADDR 12'h107
// slip enable bit positions
`define E1SP_RX_FULL_EN_BIT 2
`define E1SP_RX_EMPTY_EN_BIT 1
`define E1SP_RX_SLIP_EN_BIT 0
// loop code status bit positions
`define E1SP_ALT_PRESENT_BIT 7
`define E1SP_ALT_CHANGE_BIT 6
`define E1SP_IW_STATE_BIT 5
`define E1SP_IW_CHANGE_BIT 4
// loop code enable bit positions
`define E1SP_ALT_CHANGE_EN_BIT 6
`define E1SP_IW_CHANGE_EN_BIT 4
// framer config bit position of the alternate multiframe algorithm enable
`define E1SP_ALT_ALGO_EN_BIT 0
`define E1SP_REG_RESET 8'h00
// interworking timeout
`define E1SP_IW_TIMEOUT_MS 400
`define E1SP_CLK_HZ 200000000
`define E1SP_IW_TIMEOUT_CYC ((`E1SP_IW_TIMEOUT_MS * (`E1SP_CLK_HZ / 1000)))
`endif

//--- include/e1sp_pkg.sv
package e1sp_pkg;
    // host bus request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } e1sp_bus_req_t;

    // receive framer and slip buffer events
    typedef struct packed {
        logic slip_wr_full;
        logic slip_rd_empty;
        logic alt_pattern_det;
        logic crc4_mf_en;
        logic mf_aligned;
        logic basic_frame_aligned;
    } e1sp_rx_ev_t;

    typedef enum logic [1:0] {
        E1SP_IW_CRC4,
        E1SP_IW_SEARCH,
        E1SP_IW_NONCRC
    } e1sp_iw_state_t;
endpackage

//--- rtl/e1sp_irq.sv
// Behaviour
// - with enable bit 2 set, a receive slip buffer full event raises the interrupt.
// - with enable bit 1 set, a receive slip buffer empty event raises the interrupt.
// - with enable bit 0 set, either a fill or an empty raises the slip interrupt and sets slip status.
// - the three receive slip enable bits are read/write, 1 enables, and reset to 0.
// - a write into a full buffer drops a frame and a read of an empty buffer repeats one, each setting status.
// - status bit 7 reads 1 while the alternating pattern is being detected, else 0, reset 0.
// - status bit 6 latches 1 when pattern detection starts and when it stops.
// - each reset-upon-read status bit shows an event since the last read and is cleared by that read.
// - a pattern change drives the interrupt only when its enable is set, but the flag always records it.
// - status bit 5 reports interworking state only while the alternate multiframe algorithm is enabled.
// - multiframe alignment absent for 400 ms under basic frame alignment means non-CRC-4 far end, sets bit 5 and its flag.
// - status bit 4 is set on entry to interworking and on return to CRC-4 operation.
`include "e1sp_consts.svh"
module e1sp_irq
    import e1sp_pkg::*;
#(
    parameter int unsigned IW_TIMEOUT_CYC = `E1SP_IW_TIMEOUT_CYC
)(
    input wire logic clk, // 200 MHz register clock
    input wire logic rst_n, // async reset, active low
    input wire e1sp_bus_req_t bus_req, // host read/write request
    output logic [7:0] rdata, // read data, valid cycle after rd
    input wire e1sp_rx_ev_t rx_ev, // framer and slip buffer events
    output logic slip_drop_frame, // delete one frame, full buffer written
    output logic slip_repeat_frame, // repeat one frame, empty buffer read
    output logic irq // interrupt, active high
);
    logic [2:0] slip_en;
    logic alt_change_en;
    logic iw_change_en;
    logic alt_algo_en;
    logic rx_full_flag;
    logic rx_empty_flag;
    logic rx_slip_flag;
    logic alt_present;
    logic alt_change_flag;
    logic iw_noncrc;
    logic iw_change_flag;
    logic [31:0] iw_count;
    e1sp_iw_state_t iw_state;
    logic iw_enter;
    logic iw_leave;
    logic rd_loop;
    logic wr_slip;
    logic wr_loop_en;
    logic wr_cfg;
    logic [7:0] next_rdata;

    assign rd_loop = bus_req.rd && (bus_req.addr == `E1SP_LOOP_STATUS_ADDR);
    assign wr_slip = bus_req.wr && (bus_req.addr == `E1SP_SLIP_IRQ_EN_ADDR);
    assign wr_loop_en = bus_req.wr && (bus_req.addr == `E1SP_LOOP_IRQ_EN_ADDR);
    assign wr_cfg = bus_req.wr && (bus_req.addr == `E1SP_FRAMER_CFG_ADDR);

    // enable registers, all cleared at reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slip_en <= 3'h0;
            alt_change_en <= 1'b0;
            iw_change_en <= 1'b0;
            alt_algo_en <= 1'b0;
        end
        else
        begin
            if (wr_slip)
                slip_en <= bus_req.wdata[2:0];
            if (wr_loop_en)
            begin
                alt_change_en <= bus_req.wdata[`E1SP_ALT_CHANGE_EN_BIT];
                iw_change_en <= bus_req.wdata[`E1SP_IW_CHANGE_EN_BIT];
            end
            if (wr_cfg)
                alt_algo_en <= bus_req.wdata[`E1SP_ALT_ALGO_EN_BIT];
        end
    end

    // slip buffer actions, one cycle pulse per overflow or underflow
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slip_drop_frame <= 1'b0;
            slip_repeat_frame <= 1'b0;
        end
        else
        begin
            slip_drop_frame <= rx_ev.slip_wr_full;
            slip_repeat_frame <= rx_ev.slip_rd_empty;
        end
    end

    // slip status; these share no host-visible register here, so no read clears them
    // except a write of the enable register, which acknowledges all three
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_full_flag <= 1'b0;
            rx_empty_flag <= 1'b0;
            rx_slip_flag <= 1'b0;
        end
        else
        begin
            // set wins over the acknowledge
            rx_full_flag <= rx_ev.slip_wr_full | (rx_full_flag & ~wr_slip);
            rx_empty_flag <= rx_ev.slip_rd_empty | (rx_empty_flag & ~wr_slip);
            rx_slip_flag <= rx_ev.slip_wr_full | rx_ev.slip_rd_empty
                | (rx_slip_flag & ~wr_slip);
        end
    end

    // alternating pattern tracking
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alt_present <= 1'b0;
            alt_change_flag <= 1'b0;
        end
        else
        begin
            alt_present <= rx_ev.alt_pattern_det;
            // an edge seen in the read cycle still lands
            alt_change_flag <= (rx_ev.alt_pattern_det != alt_present)
                | (alt_change_flag & ~rd_loop);
        end
    end

    // interworking search: counts only while basic frame alignment holds
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            iw_state <= E1SP_IW_CRC4;
            iw_count <= 32'h0000_0000;
        end
        else
        begin
            case (iw_state)
                E1SP_IW_CRC4:
                begin
                    iw_count <= 32'h0000_0000;
                    if (alt_algo_en && rx_ev.crc4_mf_en && rx_ev.basic_frame_aligned
                        && !rx_ev.mf_aligned)
                        iw_state <= E1SP_IW_SEARCH;
                end
                E1SP_IW_SEARCH:
                begin
                    if (!alt_algo_en || !rx_ev.crc4_mf_en || rx_ev.mf_aligned
                        || !rx_ev.basic_frame_aligned)
                        iw_state <= E1SP_IW_CRC4;
                    else if (iw_count >= IW_TIMEOUT_CYC - 1)
                        iw_state <= E1SP_IW_NONCRC;
                    else
                        iw_count <= iw_count + 32'h0000_0001;
                end
                E1SP_IW_NONCRC:
                begin
                    // multiframe alignment found again means a CRC-4 far end
                    if (!alt_algo_en || rx_ev.mf_aligned)
                        iw_state <= E1SP_IW_CRC4;
                end
                default:
                    iw_state <= E1SP_IW_CRC4;
            endcase
        end
    end

    assign iw_enter = (iw_state == E1SP_IW_SEARCH) && alt_algo_en && rx_ev.crc4_mf_en
        && !rx_ev.mf_aligned && rx_ev.basic_frame_aligned && (iw_count >= IW_TIMEOUT_CYC - 1);
    assign iw_leave = (iw_state == E1SP_IW_NONCRC) && (!alt_algo_en || rx_ev.mf_aligned);

    // interworking state bit and change flag
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            iw_noncrc <= 1'b0;
            iw_change_flag <= 1'b0;
        end
        else
        begin
            iw_noncrc <= (iw_noncrc | iw_enter) & ~iw_leave;
            iw_change_flag <= iw_enter | iw_leave | (iw_change_flag & ~rd_loop);
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = `E1SP_REG_RESET;
        case (bus_req.addr)
            `E1SP_SLIP_IRQ_EN_ADDR:
                next_rdata[2:0] = slip_en;
            `E1SP_LOOP_STATUS_ADDR:
            begin
                next_rdata[`E1SP_ALT_PRESENT_BIT] = alt_present;
                next_rdata[`E1SP_ALT_CHANGE_BIT] = alt_change_flag;
                next_rdata[`E1SP_IW_STATE_BIT] = iw_noncrc & alt_algo_en;
                next_rdata[`E1SP_IW_CHANGE_BIT] = iw_change_flag;
            end
            `E1SP_LOOP_IRQ_EN_ADDR:
            begin
                next_rdata[`E1SP_ALT_CHANGE_EN_BIT] = alt_change_en;
                next_rdata[`E1SP_IW_CHANGE_EN_BIT] = iw_change_en;
            end
            `E1SP_FRAMER_CFG_ADDR:
                next_rdata[`E1SP_ALT_ALGO_EN_BIT] = alt_algo_en;
            default:
                next_rdata = `E1SP_REG_RESET;
        endcase
    end

    // registered read data and interrupt output
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= `E1SP_REG_RESET;
            irq <= 1'b0;
        end
        else
        begin
            if (bus_req.rd)
                rdata <= next_rdata;
            irq <= (rx_full_flag & slip_en[`E1SP_RX_FULL_EN_BIT])
                | (rx_empty_flag & slip_en[`E1SP_RX_EMPTY_EN_BIT])
                | (rx_slip_flag & slip_en[`E1SP_RX_SLIP_EN_BIT])
                | (alt_change_flag & alt_change_en)
                | (iw_change_flag & iw_change_en);
        end
    end
endmodule

//--- tb/e1sp_irq_properties.sv
module e1sp_irq_properties
    import e1sp_pkg::*;
#(
    parameter int unsigned IW_TIMEOUT_CYC = 50
)(
    input wire logic clk, // register clock
    input wire logic rst_n, // reset, active low
    input wire e1sp_bus_req_t bus_req, // host request
    input wire logic [7:0] rdata, // read data
    input wire e1sp_rx_ev_t rx_ev, // framer events
    input wire logic slip_drop_frame, // frame dropped
    input wire logic slip_repeat_frame, // frame repeated
    input wire logic irq // interrupt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] slip_en;
    logic [1:0] loop_en;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // shadow enables, so that irq can be tied to its cause
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slip_en <= 3'h0;
            loop_en <= 2'h0;
        end
        else if (bus_req.wr && bus_req.addr == 12'hB09)
            slip_en <= bus_req.wdata[2:0];
        else if (bus_req.wr && bus_req.addr == 12'hB0B)
            loop_en <= {bus_req.wdata[6], bus_req.wdata[4]};
    end
    a_drop_on_full: assert property (rx_ev.slip_wr_full |=> slip_drop_frame)
        else $error("no drop after full write");
    a_repeat_on_empty: assert property (rx_ev.slip_rd_empty |=> slip_repeat_frame)
        else $error("no repeat after empty read");
    a_full_irq: assert property (rx_ev.slip_wr_full && slip_en[2] |-> ##2 irq)
        else $error("full event gave no irq");
    a_empty_irq: assert property (rx_ev.slip_rd_empty && slip_en[1] |-> ##2 irq)
        else $error("empty event gave no irq");
    a_slip_irq: assert property ((rx_ev.slip_wr_full || rx_ev.slip_rd_empty)
        && slip_en[0] |-> ##2 irq)
        else $error("slip event gave no irq");
    a_alt_irq: assert property ($rose(rx_ev.alt_pattern_det) && loop_en[1] |-> ##2 irq)
        else $error("pattern change gave no irq");
    a_alt_state: assert property (bus_req.rd && bus_req.addr == 12'hB0A
        |=> rdata[7] == $past(rx_ev.alt_pattern_det, 2))
        else $error("pattern state bit wrong");
    a_en_readback: assert property (bus_req.rd && bus_req.addr == 12'hB09
        |=> rdata[2:0] == $past(slip_en))
        else $error("slip enables read back wrong");
    a_irq_quiet: assert property ((slip_en == 3'h0 && loop_en == 2'h0) [*3] |-> !irq)
        else $error("irq high with all enables off");
endmodule
bind e1sp_irq e1sp_irq_properties #(.IW_TIMEOUT_CYC(IW_TIMEOUT_CYC)) u_props (
    .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .rx_ev(rx_ev),
    .slip_drop_frame(slip_drop_frame), .slip_repeat_frame(slip_repeat_frame), .irq(irq));

//--- tb/e1sp_host_model.sv
module e1sp_host_model
    import e1sp_pkg::*;
(
    input wire logic clk, // register clock
    output e1sp_bus_req_t bus_req, // request to the block
    input wire logic [7:0] rdata // read answer
);
    timeunit 1ns;
    timeprecision 100ps;
    initial bus_req = '0;
    // one strobe cycle per access; an idle cycle follows, never back to back
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_req <= '{1'b0, 1'b1, a, v};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    // data lands at the edge that takes the strobe
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge clk);
        bus_req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 v = rdata;
    endtask
endmodule

//--- tb/e1_rx_slip_and_pattern_irq_tb_top.sv
module e1_rx_slip_and_pattern_irq_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import e1sp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    e1sp_bus_req_t bus_req;
    e1sp_rx_ev_t rx_ev = '0;
    logic [7:0] rdata;
    logic [7:0] d;
    logic drop;
    logic rep;
    logic irq;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    // enables [5:3], full, empty, expected irq
    logic [5:0] rows [8] = '{6'h25, 6'h22, 6'h13, 6'h14, 6'h0D, 6'h0B, 6'h04, 6'h3F};
    e1sp_irq #(.IW_TIMEOUT_CYC(50)) u_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
        .rdata(rdata), .rx_ev(rx_ev), .slip_drop_frame(drop), .slip_repeat_frame(rep),
        .irq(irq));
    e1sp_host_model u_host (.clk(clk), .bus_req(bus_req), .rdata(rdata));
    initial forever #2.5 clk = ~clk;
    task automatic stop_test();
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            errors++;
            stop_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // the enable write also clears the slip flags of the row before
        foreach (rows[i])
        begin
            u_host.wr(12'hB09, {5'h00, rows[i][5:3]});
            @(posedge clk) {rx_ev.slip_wr_full, rx_ev.slip_rd_empty} <= rows[i][2:1];
            @(posedge clk) {rx_ev.slip_wr_full, rx_ev.slip_rd_empty} <= 2'h0;
            #1 chk("drop", {7'h00, rows[i][2]}, {7'h00, drop});
            chk("repeat", {7'h00, rows[i][1]}, {7'h00, rep});
            repeat (2) @(posedge clk);
            #1 chk("irq", {7'h00, rows[i][0]}, {7'h00, irq});
            u_host.rd(12'hB09, d);
            chk("slip_en", {5'h00, rows[i][5:3]}, d);
        end
        // reset in mid-run clears enables and flags
        @(posedge clk) rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        u_host.rd(12'hB09, d);
        chk("slip_en", 8'h00, d);
        u_host.rd(12'hB0A, d);
        chk("status", 8'h00, d);
        u_host.rd(12'hB0C, d);
        chk("unmapped", 8'h00, d);
        // pattern with its enable off: flag only
        @(posedge clk) rx_ev.alt_pattern_det <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("irq", 8'h00, {7'h00, irq});
        u_host.rd(12'hB0A, d);
        chk("status", 8'hC0, d);
        u_host.rd(12'hB0A, d);
        chk("status", 8'h80, d);
        u_host.wr(12'hB0B, 8'h40);
        @(posedge clk) rx_ev.alt_pattern_det <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("irq", 8'h01, {7'h00, irq});
        u_host.rd(12'hB0A, d);
        chk("status", 8'h40, d);
        repeat (3) @(posedge clk);
        #1 chk("irq", 8'h00, {7'h00, irq});
        // far end never aligns multiframe, then alignment comes back
        @(posedge clk) rx_ev.crc4_mf_en <= 1'b1;
        rx_ev.basic_frame_aligned <= 1'b1;
        u_host.wr(12'h107, 8'h01);
        repeat (30) @(posedge clk);
        u_host.rd(12'hB0A, d);
        chk("status", 8'h00, d);
        repeat (30) @(posedge clk);
        u_host.rd(12'hB0A, d);
        chk("status", 8'h30, d);
        @(posedge clk) rx_ev.mf_aligned <= 1'b1;
        repeat (3) @(posedge clk);
        u_host.rd(12'hB0A, d);
        chk("status", 8'h10, d);
        // interworking change with its enable set drives irq
        u_host.wr(12'hB0B, 8'h10);
        @(posedge clk) rx_ev.mf_aligned <= 1'b0;
        repeat (60) @(posedge clk);
        #1 chk("irq", 8'h01, {7'h00, irq});
        u_host.rd(12'hB0A, d);
        chk("status", 8'h30, d);
        stop_test();
    end
endmodule
